/* File: core/asmr_pkg.sv */
// Types shared by the status and mode register bank
package asmr_pkg;

  typedef enum logic [1:0] {
    ASMR_WLEN_16      = 2'b00,
    ASMR_WLEN_24      = 2'b01,
    ASMR_WLEN_32_ZERO = 2'b10,
    ASMR_WLEN_32_SIGN = 2'b11
  } asmr_wlen_t;

  typedef struct packed {
    logic        rd_stb;
    logic        wr_stb;
    logic [5:0]  addr;
    logic [15:0] wdata;
    logic        noop_stb;
    logic        lock_stb;
    logic        unlock_stb;
    logic        reset_stb;
  } asmr_cmd_t;

  typedef struct packed {
    logic resync_event;
    logic regmap_crc_fault;
    logic rx_crc_fail;
    logic trim_parity_fault;
    logic isolated_side_fault;
    logic ch1_new_sample;
    logic ch0_new_sample;
  } asmr_evt_t;

  typedef struct packed {
    logic       reg_crc_en;
    logic       rx_crc_en;
    logic       crc_type;
    asmr_wlen_t sample_word_size;
    logic       timeout_en;
    logic [1:0] sample_ready_source;
    logic       sample_ready_float;
    logic       sample_ready_pulse_style;
  } asmr_cfg_t;

endpackage

/* File: core/asmr_regs.svh */
// Register offsets, field positions and reset values of the status and mode registers
`ifndef ASMR_REGS_SVH
`define ASMR_REGS_SVH

// ----------------------------------------------------------------
// Offsets
// ----------------------------------------------------------------
`define ASMR_ADDR_STATUS       6'h01
`define ASMR_ADDR_MODE         6'h02

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define ASMR_STATUS_RST        16'h0540
`define ASMR_MODE_RST          16'h0510
`define ASMR_ZERO16            16'h0000

// ----------------------------------------------------------------
// Status fields
// ----------------------------------------------------------------
`define ASMR_ST_LOCK           15
`define ASMR_ST_RESYNC         14
`define ASMR_ST_REGMAP         13
`define ASMR_ST_CRCERR         12
`define ASMR_ST_CRCTYPE        11
`define ASMR_ST_RESET          10
`define ASMR_ST_WLEN_HI        9
`define ASMR_ST_WLEN_LO        8
`define ASMR_ST_TRIM           7
`define ASMR_ST_ISO            6
`define ASMR_ST_CH1            1
`define ASMR_ST_CH0            0

// ----------------------------------------------------------------
// Mode fields
// ----------------------------------------------------------------
`define ASMR_MD_REGCRC_EN      13
`define ASMR_MD_RXCRC_EN       12
`define ASMR_MD_CRCTYPE        11
`define ASMR_MD_RESET          10
`define ASMR_MD_WLEN_HI        9
`define ASMR_MD_WLEN_LO        8
`define ASMR_MD_TIMEOUT        4
`define ASMR_MD_SRC_HI         3
`define ASMR_MD_SRC_LO         2
`define ASMR_MD_FLOAT          1
`define ASMR_MD_PULSE          0

`endif

/* File: core/asmr_status_mode.sv */
// Status and mode register bank with sticky flags and clear-on-read
//
// Operation
// - Status register at 01h, 16 bits, reset value 0540h.
// - Bit 15 set by lock command, cleared by unlock command.
// - Bit 14 set on each converter resync, held until cleared.
// - Status read clears resync, map CRC, input CRC, trim and isolation flags.
// - Bit 13 set on register map CRC fault.
// - Bit 12 set on serial input CRC failure.
// - Bit 11 shows CRC polynomial; zero after reset.
// - Bit 10 set by pin, power-on or command reset.
// - Writing 0 to mode reset bit clears status reset flag.
// - Bits 9:8 report word length; reset restores default.
// - Bit 7 set on trim parity fault, re-set if fault persists.
// - Bit 6 set on isolated side fault; reset value 1.
// - Bits 1:0 follow new-sample availability of channels 1 and 0.
// - Mode register at 02h, 16 bits read-write, reset value 0510h.
// - Mode bit 11 selects CRC polynomial, 0 CCITT, 1 ANSI.
// - Mode bits 9:8 select word length, reset 01b.
// - Mode bits 12 and 13 enable input and map CRC, off at reset.
`timescale 1ns/1ps
`include "asmr_regs.svh"

module asmr_status_mode (
  // Clock and reset
  input  wire logic                sys_clk,
  input  wire logic                rst,
  // Register commands
  input  wire asmr_pkg::asmr_cmd_t cmd,
  // Device events
  input  wire asmr_pkg::asmr_evt_t evt,
  // Read answer
  output logic [15:0]              rd_data,
  output logic                     rd_valid,
  // Configuration
  output asmr_pkg::asmr_cfg_t      cfg
);
  import asmr_pkg::*;

  // Status reset image, taken apart field by field below
  localparam logic [15:0] ST_RST = `ASMR_STATUS_RST;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [15:0] mode_reg,    mode_next;
  logic        lock_reg,    lock_next;
  logic        resync_reg,  resync_next;
  logic        regmap_reg,  regmap_next;
  logic        crcerr_reg,  crcerr_next;
  logic        rstflag_reg, rstflag_next;
  logic        trim_reg,    trim_next;
  logic        iso_reg,     iso_next;
  logic [1:0]  drdy_reg,    drdy_next;
  logic [15:0] rd_data_reg, rd_data_next;
  logic        rd_vld_reg,  rd_vld_next;

  logic [15:0] status_word;
  logic        status_rd;
  logic        mode_wr;
  logic        clr;

  function automatic logic sticky(input logic cur, input logic set, input logic clear);
    sticky = set | (cur & ~clear);
  endfunction

  // ----------------------------------------------------------------
  // Status word
  // ----------------------------------------------------------------
  always_comb begin
    status_word = `ASMR_ZERO16;
    status_word[`ASMR_ST_LOCK]    = lock_reg;
    status_word[`ASMR_ST_RESYNC]  = resync_reg;
    status_word[`ASMR_ST_REGMAP]  = regmap_reg;
    status_word[`ASMR_ST_CRCERR]  = crcerr_reg;
    status_word[`ASMR_ST_CRCTYPE] = mode_reg[`ASMR_MD_CRCTYPE];
    status_word[`ASMR_ST_RESET]   = rstflag_reg;
    status_word[`ASMR_ST_WLEN_HI:`ASMR_ST_WLEN_LO] = mode_reg[`ASMR_MD_WLEN_HI:`ASMR_MD_WLEN_LO];
    status_word[`ASMR_ST_TRIM]    = trim_reg;
    status_word[`ASMR_ST_ISO]     = iso_reg;
    status_word[`ASMR_ST_CH1]     = drdy_reg[1];
    status_word[`ASMR_ST_CH0]     = drdy_reg[0];
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    status_rd    = cmd.noop_stb | (cmd.rd_stb & (cmd.addr == `ASMR_ADDR_STATUS));
    mode_wr      = cmd.wr_stb & (cmd.addr == `ASMR_ADDR_MODE);
    clr          = status_rd;
    rd_vld_next  = cmd.rd_stb | cmd.noop_stb;
    rd_data_next = rd_data_reg;
    if (status_rd) begin
      rd_data_next = status_word;
    end else if (cmd.rd_stb) begin
      rd_data_next = (cmd.addr == `ASMR_ADDR_MODE) ? mode_reg : `ASMR_ZERO16;
    end
    mode_next = mode_wr ? cmd.wdata : mode_reg;
    lock_next = cmd.lock_stb ? 1'b1 : (cmd.unlock_stb ? 1'b0 : lock_reg);
    resync_next = sticky(resync_reg, evt.resync_event,        clr);
    regmap_next = sticky(regmap_reg, evt.regmap_crc_fault,    clr);
    crcerr_next = sticky(crcerr_reg, evt.rx_crc_fail,         clr);
    trim_next   = sticky(trim_reg,   evt.trim_parity_fault,   clr);
    iso_next    = sticky(iso_reg,    evt.isolated_side_fault, clr);
    rstflag_next = rstflag_reg & ~(mode_wr & ~cmd.wdata[`ASMR_MD_RESET]);
    drdy_next = {evt.ch1_new_sample, evt.ch0_new_sample};
    if (cmd.reset_stb) begin
      mode_next    = `ASMR_MODE_RST;
      lock_next    = ST_RST[`ASMR_ST_LOCK];
      resync_next  = ST_RST[`ASMR_ST_RESYNC];
      regmap_next  = ST_RST[`ASMR_ST_REGMAP];
      crcerr_next  = ST_RST[`ASMR_ST_CRCERR];
      rstflag_next = ST_RST[`ASMR_ST_RESET];
      trim_next    = ST_RST[`ASMR_ST_TRIM];
      iso_next     = ST_RST[`ASMR_ST_ISO];
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // reset values
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mode_reg    <= `ASMR_MODE_RST;
      lock_reg    <= ST_RST[`ASMR_ST_LOCK];
      resync_reg  <= ST_RST[`ASMR_ST_RESYNC];
      regmap_reg  <= ST_RST[`ASMR_ST_REGMAP];
      crcerr_reg  <= ST_RST[`ASMR_ST_CRCERR];
      rstflag_reg <= ST_RST[`ASMR_ST_RESET];
      trim_reg    <= ST_RST[`ASMR_ST_TRIM];
      iso_reg     <= ST_RST[`ASMR_ST_ISO];
      drdy_reg    <= ST_RST[`ASMR_ST_CH1:`ASMR_ST_CH0];
      rd_data_reg <= `ASMR_ZERO16;
      rd_vld_reg  <= 1'b0;
    end else begin
      mode_reg    <= mode_next;
      lock_reg    <= lock_next;
      resync_reg  <= resync_next;
      regmap_reg  <= regmap_next;
      crcerr_reg  <= crcerr_next;
      rstflag_reg <= rstflag_next;
      trim_reg    <= trim_next;
      iso_reg     <= iso_next;
      drdy_reg    <= drdy_next;
      rd_data_reg <= rd_data_next;
      rd_vld_reg  <= rd_vld_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rd_data = rd_data_reg;
  assign rd_valid = rd_vld_reg;
  // Plain wiring of mode fields, one driver for the whole struct
  always_comb begin
    cfg.crc_type = mode_reg[`ASMR_MD_CRCTYPE];
    cfg.sample_word_size = asmr_wlen_t'(mode_reg[`ASMR_MD_WLEN_HI:`ASMR_MD_WLEN_LO]);
    cfg.rx_crc_en  = mode_reg[`ASMR_MD_RXCRC_EN];
    cfg.reg_crc_en = mode_reg[`ASMR_MD_REGCRC_EN];
    cfg.timeout_en = mode_reg[`ASMR_MD_TIMEOUT];
    cfg.sample_ready_source      = mode_reg[`ASMR_MD_SRC_HI:`ASMR_MD_SRC_LO];
    cfg.sample_ready_float       = mode_reg[`ASMR_MD_FLOAT];
    cfg.sample_ready_pulse_style = mode_reg[`ASMR_MD_PULSE];
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_status_read;
    cmd.noop_stb || (cmd.rd_stb && cmd.addr == `ASMR_ADDR_STATUS);
  endsequence

  sequence s_quiet;
    !cmd.reset_stb && !evt.resync_event && !evt.regmap_crc_fault && !evt.rx_crc_fail
      && !evt.trim_parity_fault && !evt.isolated_side_fault;
  endsequence

  property p_soft_reset_value;
    cmd.reset_stb && !cmd.lock_stb |=> status_word[15:2] == ST_RST[15:2];
  endproperty
  a_soft_reset_value: assert property (p_soft_reset_value) else $error("status not at reset value");

  property p_lock;
    cmd.lock_stb && !cmd.reset_stb |=> lock_reg;
  endproperty
  property p_unlock;
    cmd.unlock_stb && !cmd.lock_stb |=> !lock_reg;
  endproperty
  a_lock: assert property (p_lock) else $error("lock bit not set");
  a_unlock: assert property (p_unlock) else $error("lock bit not cleared");

  property p_resync_hold;
    evt.resync_event && !cmd.reset_stb
      |=> resync_reg ##1 (resync_reg || $past(clr) || $past(cmd.reset_stb));
  endproperty
  a_resync_hold: assert property (p_resync_hold) else $error("resync flag lost");

  property p_clear_on_read;
    s_status_read ##0 s_quiet
      |=> !resync_reg && !regmap_reg && !crcerr_reg && !trim_reg && !iso_reg;
  endproperty
  a_clear_on_read: assert property (p_clear_on_read) else $error("flags not cleared by read");

  property p_fault_flags;
    (evt.regmap_crc_fault || evt.rx_crc_fail) && !cmd.reset_stb
      |=> (regmap_reg || !$past(evt.regmap_crc_fault)) && (crcerr_reg || !$past(evt.rx_crc_fail));
  endproperty
  a_fault_flags: assert property (p_fault_flags) else $error("CRC fault flag not set");

  property p_mode_write;
    cmd.wr_stb && cmd.addr == `ASMR_ADDR_MODE && !cmd.reset_stb
      |=> mode_reg == $past(cmd.wdata) && cfg.crc_type == $past(cmd.wdata[`ASMR_MD_CRCTYPE]);
  endproperty
  a_mode_write: assert property (p_mode_write) else $error("mode write not applied");

  property p_reset_flag;
    cmd.reset_stb |=> rstflag_reg && status_word[`ASMR_ST_RESET];
  endproperty
  a_reset_flag: assert property (p_reset_flag) else $error("reset flag not set");

  property p_reset_clear;
    cmd.wr_stb && cmd.addr == `ASMR_ADDR_MODE && !cmd.wdata[`ASMR_MD_RESET] && !cmd.reset_stb
      |=> !status_word[`ASMR_ST_RESET];
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("reset flag not cleared");

  property p_trim_persist;
    evt.trim_parity_fault [*2] ##0 !cmd.reset_stb |=> trim_reg;
  endproperty
  a_trim_persist: assert property (p_trim_persist) else $error("trim flag not re-set");

  property p_drdy;
    ##1 1'b1 |-> status_word[1:0] == $past({evt.ch1_new_sample, evt.ch0_new_sample});
  endproperty
  a_drdy: assert property (p_drdy) else $error("new-sample bits wrong");

  property p_capture;
    s_status_read |=> rd_valid && rd_data == $past(status_word);
  endproperty
  a_capture: assert property (p_capture) else $error("status not captured before clear");

  property p_set_wins;
    s_status_read ##0 (evt.isolated_side_fault && !cmd.reset_stb) |=> iso_reg;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("same-cycle event lost");

  property p_rd_pulse;
    !cmd.rd_stb && !cmd.noop_stb |=> !rd_valid;
  endproperty
  a_rd_pulse: assert property (p_rd_pulse) else $error("read answer without request");

  property p_mode_read;
    cmd.rd_stb && !cmd.noop_stb && cmd.addr == `ASMR_ADDR_MODE
      |=> rd_data == $past(mode_reg);
  endproperty
  a_mode_read: assert property (p_mode_read) else $error("mode read answer wrong");

  property p_other_read;
    cmd.rd_stb && !cmd.noop_stb && cmd.addr != `ASMR_ADDR_MODE && cmd.addr != `ASMR_ADDR_STATUS
      |=> rd_data == `ASMR_ZERO16;
  endproperty
  a_other_read: assert property (p_other_read) else $error("unmapped read not zero");

  property p_poly_shown;
    cmd.wr_stb && cmd.addr == `ASMR_ADDR_MODE && !cmd.reset_stb
      |=> status_word[`ASMR_ST_CRCTYPE] == $past(cmd.wdata[`ASMR_MD_CRCTYPE]);
  endproperty
  a_poly_shown: assert property (p_poly_shown) else $error("polynomial bit wrong");

  property p_wlen_shown;
    cmd.wr_stb && cmd.addr == `ASMR_ADDR_MODE && !cmd.reset_stb
      |=> status_word[`ASMR_ST_WLEN_HI:`ASMR_ST_WLEN_LO]
          == $past(cmd.wdata[`ASMR_MD_WLEN_HI:`ASMR_MD_WLEN_LO]);
  endproperty
  a_wlen_shown: assert property (p_wlen_shown) else $error("word length bits wrong");

  property p_reset_cmd_mode;
    cmd.reset_stb |=> mode_reg == `ASMR_MODE_RST && !cfg.rx_crc_en && !cfg.reg_crc_en;
  endproperty
  a_reset_cmd_mode: assert property (p_reset_cmd_mode) else $error("mode not reset");

  property p_lock_hold;
    !cmd.lock_stb && !cmd.unlock_stb && !cmd.reset_stb |=> lock_reg == $past(lock_reg);
  endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("lock bit changed alone");

endmodule

/* File: tb/asmr_host_model.sv */
// Host-side model issuing register, no-op and control commands to the bank
`timescale 1ns/1ps

module asmr_host_model (
  // Clock
  input  wire logic           sys_clk,
  // Commands to the bank
  output asmr_pkg::asmr_cmd_t cmd,
  // Read answer
  input  wire logic [15:0]    rd_data,
  input  wire logic           rd_valid
);
  import asmr_pkg::*;

  initial cmd = '0;

  // ----------------------------------------------------------------
  // Command tasks
  // ----------------------------------------------------------------
  // One command per cycle, dropped after the edge that takes it
  task automatic send(input asmr_cmd_t c);
    @(posedge sys_clk);
    cmd <= c;
    @(posedge sys_clk);
    cmd <= '0;
  endtask

  // Answer sampled once the taking edge has settled
  task automatic read(input logic [5:0] a, input logic nop, output logic [15:0] d,
                      output logic v);
    asmr_cmd_t c;
    c = '0;
    c.rd_stb = ~nop;
    c.noop_stb = nop;
    c.addr = a;
    send(c);
    #1;
    d = rd_data;
    v = rd_valid;
  endtask

  task automatic write(input logic [5:0] a, input logic [15:0] w);
    asmr_cmd_t c;
    c = '0;
    c.wr_stb = 1'b1;
    c.addr = a;
    c.wdata = w;
    send(c);
  endtask

  task automatic strobe(input logic lk, input logic ul, input logic rs);
    asmr_cmd_t c;
    c = '0;
    c.lock_stb = lk;
    c.unlock_stb = ul;
    c.reset_stb = rs;
    send(c);
  endtask

endmodule

/* File: tb/asmr_status_mode_tb_top.sv */
// Self-checking bench for the status and mode register bank
`timescale 1ns/1ps
`include "asmr_regs.svh"

module asmr_status_mode_tb_top;
  import asmr_pkg::*;

  logic        sys_clk;
  logic        rst;
  asmr_cmd_t   cmd;
  asmr_evt_t   evt;
  logic [15:0] rd_data;
  logic        rd_valid;
  asmr_cfg_t   cfg;
  int          bad_count;
  int          num_checks;
  int          stbit [5] = '{14, 13, 12, 7, 6};

  asmr_status_mode DUT (.sys_clk(sys_clk), .rst(rst), .cmd(cmd), .evt(evt),
                        .rd_data(rd_data), .rd_valid(rd_valid), .cfg(cfg));

  asmr_host_model HOST (.sys_clk(sys_clk), .cmd(cmd), .rd_data(rd_data),
                        .rd_valid(rd_valid));

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic final_report;
    if (bad_count == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic rd(input logic [5:0] a, input logic nop, input logic [15:0] e);
    logic [15:0] d;
    logic        v;
    HOST.read(a, nop, d, v);
    chk("rd_valid", 16'h0001, {15'h0000, v});
    chk("rd_data", e, d);
  endtask

  task automatic ev(input logic [6:0] v);
    @(posedge sys_clk);
    evt <= asmr_evt_t'(v);
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    evt = '0;
    bad_count = 0;
    num_checks = 0;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    rd(`ASMR_ADDR_STATUS, 1'b0, `ASMR_STATUS_RST);
    rd(`ASMR_ADDR_MODE, 1'b0, `ASMR_MODE_RST);
    chk("cfg", 16'h0030, {6'h00, cfg});
    rd(`ASMR_ADDR_STATUS, 1'b1, 16'h0500);
    for (int w = 0; w < 4; w++) begin
      HOST.write(`ASMR_ADDR_MODE, 16'h0010 | 16'(w << 8));
      rd(`ASMR_ADDR_STATUS, 1'b0, 16'(w << 8));
      chk("wlen", 16'(w), {14'h0000, cfg.sample_word_size});
    end
    HOST.write(`ASMR_ADDR_MODE, 16'h3B1D);
    rd(`ASMR_ADDR_MODE, 1'b0, 16'h3B1D);
    rd(`ASMR_ADDR_STATUS, 1'b0, 16'h0B00);
    chk("cfg", 16'h03FD, {6'h00, cfg});
    HOST.write(`ASMR_ADDR_MODE, 16'h0100);
    HOST.strobe(1'b1, 1'b0, 1'b0);
    rd(`ASMR_ADDR_STATUS, 1'b0, 16'h8100);
    rd(`ASMR_ADDR_STATUS, 1'b1, 16'h8100);
    HOST.strobe(1'b0, 1'b1, 1'b0);
    rd(`ASMR_ADDR_STATUS, 1'b0, 16'h0100);
    for (int i = 0; i < 5; i++) begin
      ev(7'h40 >> i);
      ev(7'h00);
      rd(`ASMR_ADDR_STATUS, 1'b0, 16'h0100 | (16'h0001 << stbit[i]));
      rd(`ASMR_ADDR_STATUS, 1'b1, 16'h0100);
    end
    ev(7'h08);
    rd(`ASMR_ADDR_STATUS, 1'b0, 16'h0180);
    rd(`ASMR_ADDR_STATUS, 1'b1, 16'h0180);
    ev(7'h00);
    rd(`ASMR_ADDR_STATUS, 1'b0, 16'h0180);
    rd(`ASMR_ADDR_STATUS, 1'b0, 16'h0100);
    fork
      rd(`ASMR_ADDR_STATUS, 1'b0, 16'h0100);
      begin
        ev(7'h40);
        ev(7'h00);
      end
    join
    rd(`ASMR_ADDR_STATUS, 1'b0, 16'h4100);
    rd(`ASMR_ADDR_STATUS, 1'b1, 16'h0100);
    ev(7'h02);
    rd(`ASMR_ADDR_STATUS, 1'b0, 16'h0102);
    ev(7'h01);
    rd(`ASMR_ADDR_STATUS, 1'b0, 16'h0101);
    ev(7'h00);
    rd(`ASMR_ADDR_STATUS, 1'b0, 16'h0100);
    rd(6'h03, 1'b0, 16'h0000);
    HOST.write(6'h03, 16'hFFFF);
    rd(`ASMR_ADDR_MODE, 1'b0, 16'h0100);
    HOST.strobe(1'b0, 1'b0, 1'b1);
    rd(`ASMR_ADDR_STATUS, 1'b0, `ASMR_STATUS_RST);
    rd(`ASMR_ADDR_MODE, 1'b0, `ASMR_MODE_RST);
    HOST.write(`ASMR_ADDR_MODE, 16'h0110);
    rd(`ASMR_ADDR_STATUS, 1'b0, 16'h0100);
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    rd(`ASMR_ADDR_STATUS, 1'b0, `ASMR_STATUS_RST);
    final_report;
  end

  // Cuts a hang short well beyond the fewer than two hundred cycles the tests need
  initial begin
    repeat (3000) @(posedge sys_clk);
    bad_count++;
    final_report;
  end

endmodule
